/* File: dv/miwb_builder_properties.sv */
// Checker: timing and field relations at the builder's ports
module miwb_builder_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic msg_done,
  input wire miwb_pkg::miwb_msg_s msg,
  input wire logic [5:0] fetch_index,
  input wire logic fetch_valid,
  input wire logic [15:0] fetch_addr,
  input wire logic send_data,
  input wire logic ram_wr_valid,
  input wire miwb_pkg::miwb_ram_wr_s ram_wr
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic prev_wr;
  miwb_pkg::miwb_msg_s mq;
  logic [15:0] d;
  logic info_w;
  assign d = ram_wr.data;
  // First store of a pair is the info word, the second the time tag
  assign info_w = ram_wr_valid && !prev_wr;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_wr <= 1'b0;
      mq <= '0;
    end else begin
      prev_wr <= ram_wr_valid;
      mq <= msg;
    end
  end
  apb_answer_a: assert property (psel && penable && !pready |=> pready)
    else $error("APB access not answered");
  info_store_a: assert property (msg_done && !ram_wr_valid && !prev_wr &&
    !$past(msg_done) |=> info_w && ram_wr.addr == mq.data_pointer ##1
    ram_wr_valid && ram_wr.addr == mq.data_pointer + miwb_pkg::TTAG_OFS &&
    d == mq.time_tag)
    else $error("Record store order wrong");
  fetch_addr_a: assert property (fetch_valid |-> fetch_addr ==
    mq.data_pointer + miwb_pkg::DATA_OFS + {10'h000, $past(fetch_index)})
    else $error("Fetch address wrong");
  send_busy_a: assert property (send_data |-> mq.transmit &&
    !mq.global_busy && !mq.per_command_busy_bit)
    else $error("Data sent while busy");
  bus_id_a: assert property (info_w |-> d[5] == mq.bus_b)
    else $error("Bus flag wrong");
  word_count_a: assert property (info_w |->
    d[4:0] == mq.first_command_word[4:0])
    else $error("Word count wrong");
  wct_err_a: assert property (info_w && mq.transmit |->
    d[12] == mq.extra_words)
    else $error("Word count error flag wrong");
  msg_err_a: assert property (info_w && mq.transmit && d[12] |-> d[10])
    else $error("Message error flag missing");
  was_busy_a: assert property (info_w |->
    d[9] == (mq.global_busy || mq.per_command_busy_bit))
    else $error("Busy flag wrong");
  illegal_a: assert property (info_w |-> d[8] == mq.illegal_entry)
    else $error("Illegal flag wrong");
  unused_zero_a: assert property (info_w && mq.transmit |->
    d[15:14] == 2'b00 && !d[11] && !d[7])
    else $error("Unused bits not zero");
  cover property (info_w && mq.transmit);
  cover property (fetch_valid);
  cover property (pready && pslverr);
endmodule : miwb_builder_properties
bind miwb_builder miwb_builder_properties chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .msg_done(msg_done), .msg(msg),
  .fetch_index(fetch_index), .fetch_valid(fetch_valid),
  .fetch_addr(fetch_addr), .send_data(send_data),
  .ram_wr_valid(ram_wr_valid), .ram_wr(ram_wr)
);

/* File: dv/miwb_builder_tb.sv */
// Testbench: register access, message record stores and data fetch
module miwb_builder_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic clk_en = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, fetch_valid, send_data, ram_wr_valid;
  logic msg_done = 1'b0, fetch_req = 1'b0, gap = 1'b0;
  logic [5:0] fetch_index = 6'h00;
  logic [15:0] fetch_addr;
  miwb_pkg::miwb_msg_s m = '0, mv;
  miwb_pkg::miwb_ram_wr_s ram_wr;
  logic [15:0] cw2 [8] = '{16'h3C84, 16'hFC84, 16'h3884, 16'h3C04,
    16'h3FE4, 16'h1C84, 16'h3C84, 16'h3C84};
  logic [6:0] tx [7] = '{7'h40, 7'h20, 7'h10, 7'h08, 7'h04, 7'h02, 7'h01};
  int fails = 0, samples_checked = 0, cycles = 0, n = 0;
  always #5 pclk = ~pclk;
  miwb_builder uut (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .msg_done(msg_done), .msg(m), .fetch_req(fetch_req),
    .fetch_index(fetch_index), .fetch_valid(fetch_valid),
    .fetch_addr(fetch_addr), .send_data(send_data),
    .ram_wr_valid(ram_wr_valid), .ram_wr(ram_wr)
  );
  miwb_ram_model ram (.pclk(pclk), .ram_wr_valid(ram_wr_valid),
    .ram_wr(ram_wr));
  task stop_test;
    $display("Checked %0d, failed %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test
  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Message held after the strobe: fetches read its pointer later
  task send(input logic [15:0] exp);
    @(posedge pclk);
    m <= mv;
    msg_done <= 1'b1;
    @(posedge pclk);
    msg_done <= 1'b0;
    repeat (4) @(posedge pclk);
    n++;
    check({16'h0, ram.mem[mv.data_pointer[7:0]]}, {16'h0, exp});
    check({16'h0, ram.mem[mv.data_pointer[7:0] + 8'h01]},
      {16'h0, mv.time_tag});
  endtask : send
  function automatic logic [15:0] exp_w();
    logic [15:0] w;
    logic [4:0] a2;
    logic e;
    a2 = mv.second_command_word[15:11];
    e = a2 == 5'h1F || !mv.second_command_word[10] ||
      mv.second_command_word[9:5] == 5'h00 ||
      mv.second_command_word[9:5] == 5'h1F ||
      a2 == mv.first_command_word[15:11] || !mv.status_valid ||
      mv.status_word[15:11] != a2;
    w = '0;
    w[4:0] = mv.first_command_word[4:0];
    w[5] = mv.bus_b;
    w[6] = mv.rt_to_rt && !mv.other_error && !(gap && mv.gap_seen) &&
      (mv.transmit ? !mv.extra_words : !e && !mv.short_words);
    w[8] = mv.illegal_entry;
    w[9] = mv.global_busy || mv.per_command_busy_bit;
    if (mv.transmit) begin
      w[13] = gap ? mv.gap_seen : mv.broadcast;
      w[12] = mv.extra_words;
      w[10] = mv.extra_words || (gap && mv.gap_seen);
    end else w[7] = mv.rt_to_rt && e;
    return w;
  endfunction : exp_w
  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, miwb_pkg::CTRL_OFF, 32'h0);
    check(rd, miwb_pkg::CTRL_RESET);
    apb(1'b0, 8'h40, 32'h0);
    check({rd[30:0], err}, 32'h1);
    $display("Test registers done");
    for (int i = 0; i < 8; i++) begin
      mv = '0;
      mv.rt_to_rt = 1'b1;
      mv.first_command_word = 16'h1840;
      mv.second_command_word = cw2[i];
      mv.status_valid = i != 7;
      mv.status_word = (i == 6) ? 16'h4000 : 16'h3800;
      mv.bus_b = i[0];
      mv.data_pointer = 16'(4 * i);
      mv.time_tag = 16'(256 + i);
      send(exp_w());
    end
    $display("Test receive done");
    for (int g = 0; g < 2; g++) begin
      gap = g[0];
      apb(1'b1, miwb_pkg::CTRL_OFF, {30'h0, 1'b1, gap});
      for (int i = 0; i < 7; i++) begin
        mv = '0;
        mv.transmit = 1'b1;
        mv.first_command_word = 16'h1C5F;
        mv.second_command_word = cw2[0];
        mv.status_valid = 1'b1;
        mv.status_word = 16'h3800;
        {mv.rt_to_rt, mv.gap_seen, mv.broadcast, mv.extra_words,
          mv.global_busy, mv.per_command_busy_bit, mv.illegal_entry} = tx[i];
        mv.data_pointer = 16'(64 + 8 * i);
        mv.time_tag = 16'(512 + i);
        send(exp_w());
        check({31'h0, send_data}, {31'h0, !(tx[i][2] | tx[i][1])});
      end
    end
    fetch_req <= 1'b1;
    fetch_index <= 6'h3F;
    @(posedge pclk);
    fetch_req <= 1'b0;
    @(posedge pclk);
    check({15'h0, fetch_valid, fetch_addr},
      {15'h0, 1'b1, mv.data_pointer + 16'h0041});
    apb(1'b0, miwb_pkg::MSG_COUNT_OFF, 32'h0);
    check(rd, 32'(n));
    apb(1'b0, miwb_pkg::LAST_ADDR_OFF, 32'h0);
    check(rd, {16'h0, mv.data_pointer});
    apb(1'b0, miwb_pkg::LAST_WORD_OFF, 32'h0);
    check(rd, {16'h0, exp_w()});
    apb(1'b0, miwb_pkg::STATUS_OFF, 32'h0);
    check(rd, 32'h1);
    $display("Test transmit done");
    stop_test();
  end
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      stop_test();
    end
  end
endmodule : miwb_builder_tb

/* File: dv/miwb_ram_model.sv */
// Shared RAM model: host-prepared records and device stores
module miwb_ram_model (
  input wire logic pclk,
  input wire logic ram_wr_valid,
  input wire miwb_pkg::miwb_ram_wr_s ram_wr
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [256];
  // Host fills every word with A5A5, tables included; device overwrites slots
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 16'hA5A5;
  end
  always @(posedge pclk) begin
    if (ram_wr_valid) mem[ram_wr.addr[7:0]] <= ram_wr.data;
  end
endmodule : miwb_ram_model

/* File: hdl/miwb_builder.sv */
// Module: builds and stores the subaddress message information word
//
// Contract
// - Bit 7 on broadcast, receive, mode or repeated-address second command.
// - Bit 7 also on invalid or misaddressed transmitter status word.
// - Receive word bit 6 set only for error-free RT-to-RT transfer.
// - Bit 5 is 0 for bus A, 1 for bus B.
// - Bits 4-0 copy command word count; zero means 32 words.
// - Info word at pointer, time tag at plus one, data from plus two.
// - In gap mode, transmit bit 13 flags activity where gap expected.
// - Otherwise bit 13 flags a broadcast message.
// - Transmit bit 12 flags unexpected data words after transmit command.
// - Bit 10 set whenever bit 12 or bit 13 error arises.
// - Busy answer, global or per command, sets bit 9; no data sent.
// - Bit 8 set when matching illegalization table entry is one.
// - Transmit word bit 6 set only for error-free RT-to-RT transfer.
//
// Chosen here: the address map and the APB slave port.
module miwb_builder (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Completed message from the protocol engine
  input wire logic msg_done,
  input wire miwb_pkg::miwb_msg_s msg,
  // Data word fetch for transmit
  input wire logic fetch_req,
  input wire logic [5:0] fetch_index,
  output logic fetch_valid,
  output logic [15:0] fetch_addr,
  output logic send_data,
  // Shared RAM write port
  output logic ram_wr_valid,
  output miwb_pkg::miwb_ram_wr_s ram_wr
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [15:0] rec_addr(input logic [15:0] base,
                                           input logic [15:0] ofs);
    rec_addr = base + ofs;
  endfunction : rec_addr

  typedef enum logic [1:0] {
    MIWB_IDLE,
    MIWB_INFO,
    MIWB_TTAG
  } miwb_state_e;

  miwb_state_e state;
  logic [31:0] ctrl;
  logic [15:0] last_word;
  logic [15:0] last_addr;
  logic [15:0] msg_count;
  logic [15:0] info_word;
  logic [15:0] held_ptr;
  logic [15:0] held_ttag;
  logic tx_err;
  logic busy;
  logic err_free;
  logic gap_or_broadcast_flag;
  logic [15:0] active_cw;
  logic gap_mode;
  logic enabled;

  assign gap_mode = ctrl[miwb_pkg::CTRL_GAP_MODE_BIT];
  assign enabled = ctrl[miwb_pkg::CTRL_ENABLE_BIT];

  miwb_tx_err u_tx_err (
    .first_command_word(msg.first_command_word),
    .second_command_word(msg.second_command_word),
    .status_valid(msg.status_valid),
    .status_word(msg.status_word),
    .rt_transfer_tx_error(tx_err)
  );

  // ----------------------------------------------------------------------
  // Information word assembly
  // ----------------------------------------------------------------------
  assign busy = msg.global_busy || msg.per_command_busy_bit;
  assign active_cw = msg.first_command_word;

  always_comb begin
    info_word = 16'h0000;
    gap_or_broadcast_flag = gap_mode ? msg.gap_seen : msg.broadcast;
    if (msg.transmit) begin
      // Bits 15, 14, 11, 7 remain zero; broadcast is no error
      err_free = msg.rt_to_rt && !(gap_mode && msg.gap_seen) &&
        !msg.extra_words && !msg.other_error;
      info_word[miwb_pkg::W_GAP_OR_BROADCAST_FLAG] = gap_or_broadcast_flag;
      info_word[miwb_pkg::W_WCT_ERR] = msg.extra_words;
      info_word[miwb_pkg::W_MSG_ERR] =
        msg.extra_words || (gap_mode && msg.gap_seen);
    end else begin
      err_free = msg.rt_to_rt && !tx_err && !msg.other_error &&
        !msg.short_words && !(gap_mode && msg.gap_seen);
      info_word[miwb_pkg::W_TX_ERR] = msg.rt_to_rt && tx_err;
    end
    info_word[miwb_pkg::W_WAS_BUSY] = busy;
    info_word[miwb_pkg::W_ILLEGAL] = msg.illegal_entry;
    info_word[miwb_pkg::W_RT_RT] = err_free;
    info_word[miwb_pkg::W_BUS_ID] = msg.bus_b;
    info_word[4:0] = active_cw[4:0];
  end

  // ----------------------------------------------------------------------
  // Store sequence: info word, then time tag, after completion
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= MIWB_IDLE;
      ram_wr_valid <= 1'b0;
      ram_wr <= '0;
      held_ptr <= 16'h0000;
      held_ttag <= 16'h0000;
      last_word <= 16'h0000;
      last_addr <= 16'h0000;
    end else if (clk_en) begin
      unique case (state)
        MIWB_IDLE: begin
          ram_wr_valid <= 1'b0;
          if (msg_done && enabled) begin
            held_ptr <= msg.data_pointer;
            held_ttag <= msg.time_tag;
            last_word <= info_word;
            ram_wr_valid <= 1'b1;
            ram_wr.addr <= rec_addr(msg.data_pointer,
                                    miwb_pkg::INFO_OFS);
            ram_wr.data <= info_word;
            last_addr <= msg.data_pointer;
            state <= MIWB_INFO;
          end
        end
        MIWB_INFO: begin
          ram_wr_valid <= 1'b1;
          ram_wr.addr <= rec_addr(held_ptr, miwb_pkg::TTAG_OFS);
          ram_wr.data <= held_ttag;
          state <= MIWB_TTAG;
        end
        MIWB_TTAG: begin
          ram_wr_valid <= 1'b0;
          state <= MIWB_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Transmit data fetch addresses
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fetch_valid <= 1'b0;
      fetch_addr <= 16'h0000;
      send_data <= 1'b0;
    end else if (clk_en) begin
      // Busy answer suppresses every data word
      send_data <= msg.transmit && !busy && enabled;
      fetch_valid <= fetch_req && enabled && !busy;
      fetch_addr <= rec_addr(msg.data_pointer,
        miwb_pkg::DATA_OFS + {10'h000, fetch_index});
    end
  end

  // ----------------------------------------------------------------------
  // APB slave: one wait state, unmapped reads zero with error
  // ----------------------------------------------------------------------
  logic acc;
  logic mapped;
  assign acc = psel && penable && !pready;
  assign mapped = (paddr == miwb_pkg::CTRL_OFF) ||
    (paddr == miwb_pkg::STATUS_OFF) || (paddr == miwb_pkg::LAST_WORD_OFF) ||
    (paddr == miwb_pkg::LAST_ADDR_OFF) || (paddr == miwb_pkg::MSG_COUNT_OFF);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= miwb_pkg::CTRL_RESET;
    end else if (clk_en && psel && penable && pready && pwrite &&
                 paddr == miwb_pkg::CTRL_OFF) begin
      // Takes effect at the completing edge, as the master sees it
      ctrl <= {30'h000_0000, pwdata[1:0]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      msg_count <= 16'h0000;
    end else if (clk_en && state == MIWB_INFO) begin
      // Wraps silently; software compares deltas
      msg_count <= msg_count + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (clk_en) begin
      pready <= acc;
      pslverr <= acc && !mapped;
      prdata <= 32'h0000_0000;
      if (acc && !pwrite) begin
        unique case (paddr)
          miwb_pkg::CTRL_OFF: prdata <= ctrl;
          miwb_pkg::STATUS_OFF:
            prdata <= {30'h000_0000, state != MIWB_IDLE, send_data};
          miwb_pkg::LAST_WORD_OFF: prdata <= {16'h0000, last_word};
          miwb_pkg::LAST_ADDR_OFF: prdata <= {16'h0000, last_addr};
          miwb_pkg::MSG_COUNT_OFF: prdata <= {16'h0000, msg_count};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule : miwb_builder

/* File: hdl/miwb_pkg.sv */
// Package: constants and carriers for the message information word builder
package miwb_pkg;

  // APB register byte offsets
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] STATUS_OFF = 8'h04;
  localparam logic [7:0] LAST_WORD_OFF = 8'h08;
  localparam logic [7:0] LAST_ADDR_OFF = 8'h0C;
  localparam logic [7:0] MSG_COUNT_OFF = 8'h10;

  // Control register field positions and reset value
  localparam int CTRL_GAP_MODE_BIT = 0;
  localparam int CTRL_ENABLE_BIT = 1;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0002;

  // Information word bit positions
  localparam int W_GAP_OR_BROADCAST_FLAG = 13;
  localparam int W_WCT_ERR = 12;
  localparam int W_MSG_ERR = 10;
  localparam int W_WAS_BUSY = 9;
  localparam int W_ILLEGAL = 8;
  localparam int W_TX_ERR = 7;
  localparam int W_RT_RT = 6;
  localparam int W_BUS_ID = 5;

  // Command word fields
  localparam int CW_ADDR_HI = 15;
  localparam int CW_ADDR_LO = 11;
  localparam int CW_TR_BIT = 10;
  localparam int CW_SA_HI = 9;
  localparam int CW_SA_LO = 5;
  localparam logic [4:0] BCAST_ADDR = 5'h1F;
  localparam logic [4:0] MODE_SA_LO = 5'h00;
  localparam logic [4:0] MODE_SA_HI = 5'h1F;

  // Record layout offsets from the data pointer
  localparam logic [15:0] INFO_OFS = 16'h0000;
  localparam logic [15:0] TTAG_OFS = 16'h0001;
  localparam logic [15:0] DATA_OFS = 16'h0002;

  // Message summary from the protocol engine, valid with its strobe
  typedef struct packed {
    logic transmit;
    logic rt_to_rt;
    logic [15:0] first_command_word;
    logic [15:0] second_command_word;
    logic status_valid;
    logic [15:0] status_word;
    logic bus_b;
    logic gap_seen;
    logic broadcast;
    logic extra_words;
    logic short_words;
    logic other_error;
    logic global_busy;
    logic per_command_busy_bit;
    logic illegal_entry;
    logic [15:0] data_pointer;
    logic [15:0] time_tag;
  } miwb_msg_s;

  // Word store request toward shared RAM
  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] data;
  } miwb_ram_wr_s;

endpackage : miwb_pkg

/* File: hdl/miwb_tx_err.sv */
// Module: RT-RT transmitter error detection on the second command word and status word
module miwb_tx_err (
  input wire logic [15:0] first_command_word,
  input wire logic [15:0] second_command_word,
  input wire logic status_valid,
  input wire logic [15:0] status_word,
  output logic rt_transfer_tx_error
);

  logic [4:0] addr1;
  logic [4:0] addr2;
  logic [4:0] sa2;
  logic cw2_bad;
  logic stat_bad;

  assign addr1 = first_command_word[miwb_pkg::CW_ADDR_HI:miwb_pkg::CW_ADDR_LO];
  assign addr2 =
    second_command_word[miwb_pkg::CW_ADDR_HI:miwb_pkg::CW_ADDR_LO];
  assign sa2 = second_command_word[miwb_pkg::CW_SA_HI:miwb_pkg::CW_SA_LO];

  assign cw2_bad = (addr2 == miwb_pkg::BCAST_ADDR) ||
    !second_command_word[miwb_pkg::CW_TR_BIT] ||
    (sa2 == miwb_pkg::MODE_SA_LO) || (sa2 == miwb_pkg::MODE_SA_HI) ||
    ((addr2 == addr1) && (addr1 != miwb_pkg::BCAST_ADDR));
  assign stat_bad = !status_valid ||
    (status_word[miwb_pkg::CW_ADDR_HI:miwb_pkg::CW_ADDR_LO] != addr2);
  assign rt_transfer_tx_error = cw2_bad || stat_bad;

endmodule : miwb_tx_err
